// ==== qlc_defs.svh ====
`ifndef QLC_DEFS_SVH
`define QLC_DEFS_SVH

`define QLC_ADDR_SNAPSHOT 32'h2040_0204
`define QLC_ADDR_RUN      32'h2040_0300
`define QLC_ADDR_ZERO     32'h2040_0310
`define QLC_ADDR_LATCH    32'h2040_0320
`define QLC_BIT_CMD       0
`define QLC_RST_COUNT     32'h0000_0000
`define QLC_RST_RUN       1'b0

`endif

// ==== qlc_pkg.sv ====
`default_nettype none
package qlc_pkg;

  // Decoded encoder step: one pulse and its direction
  typedef struct packed {
    logic step;
    logic up;
  } qlc_step_t;

  // Peek/poke request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } qlc_req_t;

endpackage
`default_nettype wire

// ==== qlc_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qlc_defs.svh"

module qlc_counter #(
  parameter int CNT_W = 32
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              enc_a,
  input  wire logic              enc_b,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  input  wire logic [31:0]       bus_addr,
  input  wire logic [31:0]       bus_wdata,
  output var  logic [31:0]       bus_rdata,
  output var  logic              bus_rvalid,
  output var  logic              enc_a_level,
  output var  logic              enc_b_level
);

  qlc_pkg::qlc_req_t  req;
  qlc_pkg::qlc_step_t stp;

  logic [1:0]       sync1;
  logic [1:0]       sync2;
  logic [1:0]       prev;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] snapshot;
  logic             run;
  logic             zero_cmd;
  logic             latch_cmd;

  // Next-state values for the count, snapshot, run, command and read registers
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_snapshot;
  logic             next_run;
  logic             next_zero_cmd;
  logic             next_latch_cmd;
  logic             next_rvalid;
  logic [31:0]      next_rdata;
  logic [31:0]      read_word;
  logic [CNT_W-1:0] stepped;

  // Decoded address hits and write strobes
  logic             hit_run;
  logic             hit_zero;
  logic             hit_latch;
  logic             hit_snap;
  logic             cmd_bit;
  logic             write_run;
  logic             write_zero;
  logic             write_latch;
  logic             count_step;

  // Gray-sequence decoder; a double change is illegal and dropped
  function automatic qlc_pkg::qlc_step_t decode(input logic [1:0] p,
                                                input logic [1:0] c);
    qlc_pkg::qlc_step_t r;
    r.step = ^(p ^ c);
    r.up   = p[0] ^ c[1];
    return r;
  endfunction

  // Full compare; aliases would let stray pokes fire commands
  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [31:0] base);
    return a == base;
  endfunction

  assign req = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

  assign hit_run   = addr_is(req.addr, `QLC_ADDR_RUN);
  assign hit_zero  = addr_is(req.addr, `QLC_ADDR_ZERO);
  assign hit_latch = addr_is(req.addr, `QLC_ADDR_LATCH);
  assign hit_snap  = addr_is(req.addr, `QLC_ADDR_SNAPSHOT);
  assign cmd_bit   = req.wdata[`QLC_BIT_CMD];

  // Only bit 0 of a poke matters; a 0 to a command does nothing
  assign write_run   = req.wr && hit_run;
  assign write_zero  = req.wr && hit_zero && cmd_bit;
  assign write_latch = req.wr && hit_latch && cmd_bit;

  // two-stage synchroniser
  // Third stage keeps the last pair for edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev  <= 2'h0;
    end
    else
    begin
      sync1 <= {enc_b, enc_a};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // pulse per edge, direction from order
  assign stp = decode(prev, sync2);

  assign next_run = write_run ? cmd_bit : run;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      run <= `QLC_RST_RUN;
    else
      run <= next_run;
  end

  // command bits self-clear after one cycle
  // One-cycle pulses; their addresses are not readable, so a read there gives zero
  assign next_zero_cmd  = write_zero;
  assign next_latch_cmd = write_latch;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zero_cmd  <= 1'b0;
      latch_cmd <= 1'b0;
    end
    else
    begin
      zero_cmd  <= next_zero_cmd;
      latch_cmd <= next_latch_cmd;
    end
  end

  // up/down step; natural wrap
  // Wrap is plain modular arithmetic; no overflow flag
  assign count_step = run && stp.step;
  assign stepped    = stp.up ? count + CNT_W'(1) : count - CNT_W'(1);

  assign next_count = zero_cmd   ? CNT_W'(`QLC_RST_COUNT) :
                      count_step ? stepped : count;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= CNT_W'(`QLC_RST_COUNT);
    else
      count <= next_count;
  end

  // snapshot takes the count before this cycle's step
  assign next_snapshot = latch_cmd ? count : snapshot;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      snapshot <= CNT_W'(`QLC_RST_COUNT);
    else
      snapshot <= next_snapshot;
  end

  // only the snapshot and the run bit are readable; unmapped reads give zero
  // Read data holds between reads so a slow poll still sees it
  assign read_word   = hit_snap ? 32'(snapshot) :
                       hit_run  ? {31'h0, run} : 32'h0000_0000;
  assign next_rvalid = req.rd;
  assign next_rdata  = req.rd ? read_word : bus_rdata;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_rdata  <= 32'h0000_0000;
      bus_rvalid <= 1'b0;
    end
    else
    begin
      bus_rdata  <= next_rdata;
      bus_rvalid <= next_rvalid;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enc_a_level <= 1'b0;
      enc_b_level <= 1'b0;
    end
    else
    begin
      enc_a_level <= sync2[0];
      enc_b_level <= sync2[1];
    end
  end

endmodule

`default_nettype wire

// ==== qlc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qlc_defs.svh"
module qlc_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        enc_a,
  input wire logic        enc_b,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic        bus_rvalid,
  input wire logic        enc_a_level,
  input wire logic        enc_b_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_run_wr;
    bus_wr && bus_addr == `QLC_ADDR_RUN;
  endsequence
  sequence s_run_rd;
    bus_rd && !bus_wr && bus_addr == `QLC_ADDR_RUN;
  endsequence
  AST_RV: assert property (bus_rd |=> bus_rvalid) else $error("no rvalid");
  AST_NORV: assert property (!bus_rd |=> !bus_rvalid) else $error("rv");
  AST_HOLD: assert property (!bus_rd |=> $stable(bus_rdata)) else $error("rd");
  AST_UNMAP: assert property (bus_rd && bus_addr == 32'h0 |=>
    bus_rdata == 32'h0) else $error("unmapped read");
  AST_RUN: assert property (s_run_wr ##1 s_run_rd |=>
    bus_rdata[0] == $past(bus_wdata[0], 2)) else $error("run lost");
  AST_LA: assert property ($stable(enc_a)[*4] |-> enc_a_level == enc_a)
    else $error("level a");
  AST_LB: assert property ($stable(enc_b)[*4] |-> enc_b_level == enc_b)
    else $error("level b");
  AST_RST: assert property ($rose(arst_n) |-> bus_rdata == 32'h0)
    else $error("reset data");
endmodule
bind qlc_counter qlc_props u_props (.*);
`default_nettype wire

// ==== qlc_enc.sv ====
`timescale 1ns/1ps
`default_nettype none
module qlc_enc (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic up,
  output var  logic a,
  output var  logic b
);
  logic [1:0] p = 2'h0;
  always @(posedge clk)
  begin
    if (go)
      p <= up ? p + 2'h1 : p - 2'h1;
  end
  // B leads A when counting up: {a,b} walks 00,01,11,10
  assign {a, b} = {p[1], ^p};
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qlc_defs.svh"
module testbench;
  logic        clk = 0, arst_n = 0, wr = 0, rd = 0, go = 0, up = 1;
  logic        a, b, rv, la, lb, gv;
  logic [31:0] ad = 0, wd = 0, rdat, got, prv;
  int          errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  qlc_enc enc (.clk, .go, .up, .a, .b);
  qlc_counter dut (.clk, .arst_n, .enc_a(a), .enc_b(b), .bus_wr(wr),
    .bus_rd(rd), .bus_addr(ad), .bus_wdata(wd), .bus_rdata(rdat),
    .bus_rvalid(rv), .enc_a_level(la), .enc_b_level(lb));
  task chk(logic [31:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  // Read answer stands half a cycle after the taking edge: grab it before
  // the strobes drop; the trailing edge keeps two calls apart
  task acc(logic w, logic [31:0] adr, dat);
    wr = w;
    rd = !w;
    ad = adr;
    wd = dat;
    @(negedge clk);
    gv = rv;
    got = rdat;
    wr = 0;
    rd = 0;
    @(negedge clk);
  endtask
  task rdc(logic [31:0] adr, e);
    acc(0, adr, 0);
    chk(gv === 1'b1 ? got : ~e, e);
  endtask
  // Write, then read the same register at the very next edge
  task wr_rd(logic [31:0] adr, dat, e);
    wr = 1;
    ad = adr;
    wd = dat;
    @(negedge clk);
    wr = 0;
    rd = 1;
    @(negedge clk);
    gv = rv;
    got = rdat;
    rd = 0;
    @(negedge clk);
    chk(gv === 1'b1 ? got : ~e, e);
  endtask
  task snap(logic [31:0] e);
    repeat (4) @(negedge clk);
    acc(1, `QLC_ADDR_LATCH, 1);
    @(negedge clk);
    rdc(`QLC_ADDR_SNAPSHOT, e);
  endtask
  task mv(int n, logic u);
    up = u;
    repeat (n)
    begin
      go = 1;
      @(negedge clk);
      go = 0;
      @(negedge clk);
    end
  endtask
  task end_of_test;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #4000;
    errors++;
    end_of_test;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1;
    snap(32'h0);
    prv = got;
    rdc(`QLC_ADDR_RUN, 32'h0);
    rdc(32'h0, 32'h0);
    wr_rd(`QLC_ADDR_RUN, 32'h1, 32'h1);
    mv(5, 1);
    snap(32'h5);
    chk({31'h0, $signed(got - prv) > 0}, 32'h1);
    prv = got;
    mv(7, 0);
    snap(32'hFFFF_FFFE);
    chk({31'h0, $signed(got - prv) < 0}, 32'h1);
    acc(1, `QLC_ADDR_ZERO, 0);
    snap(32'hFFFF_FFFE);
    acc(1, `QLC_ADDR_RUN, 0);
    mv(3, 1);
    snap(32'hFFFF_FFFE);
    acc(1, `QLC_ADDR_ZERO, 1);
    snap(32'h0);
    acc(1, `QLC_ADDR_RUN, 1);
    mv(2, 1);
    rdc(`QLC_ADDR_SNAPSHOT, 32'h0);
    chk({30'h0, la, lb}, {30'h0, a, b});
    arst_n = 0;
    repeat (2) @(negedge clk);
    arst_n = 1;
    snap(32'h0);
    rdc(`QLC_ADDR_RUN, 32'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
